// *** logic/sacc_pkg.sv ***
// Package: constants and carriers for the converter control block
package sacc_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CLKSEL = 8'h04;
    localparam logic [7:0] ADDR_CHAN   = 8'h08;
    localparam logic [7:0] ADDR_TIMING = 8'h0c;
    localparam logic [7:0] ADDR_RESULT = 8'h10;
    localparam logic [7:0] ADDR_PREV   = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_THRESH = 8'h1c;
    localparam logic [7:0] ADDR_SUM    = 8'h20;
    localparam logic [7:0] ADDR_DEV    = 8'h24;

    // ------------------------------------------------------------------
    // Control register bit positions
    // ------------------------------------------------------------------
    localparam int CTRL_ON   = 0;
    localparam int CTRL_GO   = 1;
    localparam int CTRL_REPEAT_RUN = 2;
    localparam int CTRL_RC   = 3;
    localparam int CTRL_JUST = 4;
    localparam int CTRL_PSIS = 5;
    localparam int CTRL_DSEN = 6;
    localparam int CTRL_IE   = 7;
    localparam int CTRL_TRGE = 8;
    localparam int CTRL_TIE  = 9;
    localparam int CTRL_ABOV = 10;
    localparam int CTRL_REF  = 12;

    // Status bit positions (DONE, THR and MATH write one to clear)
    localparam int STAT_DONE = 0;
    localparam int STAT_THR  = 1;
    localparam int STAT_MATH = 2;
    localparam int STAT_BUSY = 3;
    localparam int STAT_PEND = 4;

    // ------------------------------------------------------------------
    // Widths, counts and reset values
    // ------------------------------------------------------------------
    localparam int RES_W   = 12;
    localparam int CNT_W   = 13;
    localparam int DIV_W   = 6;
    localparam int CHAN_W  = 6;
    localparam logic [3:0] SAR_LAST_BIT  = 4'hb;
    localparam logic [3:0] JUST_SHIFT    = 4'h4;
    localparam logic [12:0] CTRL_RESET   = 13'h0000;
    localparam int SYS_CLK_MHZ = 50;
    localparam int INSTR_NS    = 125;  // one instruction period
    localparam int INSTR_CYC   =
        (INSTR_NS * SYS_CLK_MHZ + 999) / 1000;

    typedef enum logic [2:0] {
        SACC_IDLE = 3'b000,
        SACC_WAIT = 3'b001,
        SACC_PRE  = 3'b010,
        SACC_ACQ  = 3'b011,
        SACC_CONV = 3'b100,
        SACC_DONE = 3'b101
    } sacc_state_e;

    // Analog side request
    typedef struct packed {
        logic              power;
        logic              sample;
        logic              precharge;
        logic [CHAN_W-1:0] channel;
        logic [1:0]        pos_ref;
        logic [RES_W-1:0]  trial;
    } sacc_ana_s;

endpackage

// *** logic/sacc_top.sv ***
// Converter control: APB registers, timing, SAR loop and result maths
`timescale 1ns/1ns

module sacc_top (
    input  wire logic                I_CLK_SYS,
    input  wire logic                I_RST_N,
    input  wire logic                PSEL,
    input  wire logic                PENABLE,
    input  wire logic                PWRITE,
    input  wire logic [7:0]          PADDR,
    input  wire logic [31:0]         PWDATA,
    output logic      [31:0]         PRDATA,
    output logic                     PREADY,
    output logic                     PSLVERR,
    input  wire logic                i_sleep,
    input  wire logic                i_rc_tick,
    input  wire logic                i_trigger,
    input  wire logic                i_compare_hi,
    output sacc_pkg::sacc_ana_s      o_analog,
    output logic                     o_wake
);
    import sacc_pkg::*;

    // ------------------------------------------------------------------
    // State record
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [13:0]        ctrl;
        logic [DIV_W-1:0]   div;
        logic [CHAN_W-1:0]  chan;
        logic [CNT_W-1:0]   pre_cnt;
        logic [CNT_W-1:0]   acq_cnt;
        logic [RES_W-1:0]   result;
        logic [RES_W-1:0]   prev;
        logic [15:0]        setpoint;
        logic [15:0]        thresh;
        logic [31:0]        sum;
        logic [15:0]        dev;
        logic               done_f;
        logic               thr_f;
        logic               math_f;
        logic               pend;
        logic               powered;
        logic               trig_q;
        logic               half;
        logic               odd;      // Double-sample parity
        logic [DIV_W-1:0]   div_cnt;
        logic [CNT_W-1:0]   tmr;
        logic [3:0]         bitn;
        logic [RES_W-1:0]   sar;
        logic [31:0]        rdata;
        sacc_state_e        st;
    } sacc_st_s;

    sacc_st_s s_q;
    sacc_st_s s_d;

    logic wr;
    logic rd;
    logic tick;
    logic rc_mode;
    logic trig_rise;
    logic start;
    logic [15:0] just;
    logic [15:0] diff;

    // Left or right placement of a 12-bit value in 16 bits
    function automatic logic [15:0] place(input logic [RES_W-1:0] v,
                                          input logic left);
        place = left ? {v, JUST_SHIFT'(4'h0)} : {4'h0, v};
    endfunction

    // ------------------------------------------------------------------
    // Bus strobes and conversion clock enable
    // ------------------------------------------------------------------
    assign wr      = PSEL & PENABLE & PWRITE;
    assign rd      = PSEL & ~PENABLE & ~PWRITE;
    assign rc_mode = s_q.ctrl[CTRL_RC];
    assign tick    = rc_mode ? i_rc_tick
                   : (s_q.div_cnt == s_q.div) & s_q.half;
    assign trig_rise = s_q.ctrl[CTRL_TRGE] & i_trigger & ~s_q.trig_q;
    assign just    = place(s_q.result, ~s_q.ctrl[CTRL_JUST]);
    assign diff    = 16'({4'h0, s_q.sar}) - s_q.setpoint;     // Finishing value
    // Conversion may start only with the module on and clocks allowed
    assign start   = s_q.ctrl[CTRL_ON] & s_q.ctrl[CTRL_GO]
                   & (rc_mode | ~i_sleep) & s_q.st == SACC_IDLE;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.trig_q = i_trigger;
        // Divider: system clock over 2*(code+1)
        if (!rc_mode) begin
            if (s_q.div_cnt == s_q.div) begin
                s_d.div_cnt = '0;
                s_d.half    = ~s_q.half;
            end else begin
                s_d.div_cnt = s_q.div_cnt + 1'b1;
            end
        end
        // Trigger edge sets request, held in Sleep off RC
        if (trig_rise & s_q.ctrl[CTRL_ON]) begin
            if (i_sleep & ~rc_mode) begin
                s_d.pend = 1'b1;
            end else begin
                s_d.ctrl[CTRL_GO] = 1'b1;
            end
        end
        // Remembered trigger fires once Sleep ends
        if (s_q.pend & ~i_sleep) begin
            s_d.pend          = 1'b0;
            s_d.ctrl[CTRL_GO] = 1'b1;
        end
        // Register writes
        // Flag clears here lose to a hardware set further down
        if (wr) begin
            unique case (PADDR)
                ADDR_CTRL:   s_d.ctrl = PWDATA[13:0];
                ADDR_CLKSEL: s_d.div  = PWDATA[DIV_W-1:0];
                ADDR_CHAN:   s_d.chan = PWDATA[CHAN_W-1:0];
                ADDR_TIMING: begin
                    s_d.pre_cnt = PWDATA[CNT_W-1:0];
                    s_d.acq_cnt = PWDATA[16+CNT_W-1:16];
                end
                ADDR_RESULT: s_d.result = PWDATA[RES_W-1:0];
                ADDR_PREV:   s_d.prev   = PWDATA[RES_W-1:0];
                ADDR_STATUS: begin
                    if (PWDATA[STAT_DONE]) s_d.done_f = 1'b0;
                    if (PWDATA[STAT_THR])  s_d.thr_f  = 1'b0;
                    if (PWDATA[STAT_MATH]) s_d.math_f = 1'b0;
                end
                ADDR_THRESH: begin
                    s_d.setpoint = PWDATA[15:0];
                    s_d.thresh   = PWDATA[31:16];
                end
                default: ;
            endcase
            if (PADDR == ADDR_CTRL & PWDATA[CTRL_ON]) begin
                s_d.powered = 1'b1;
            end
        end
        // Conversion sequence: start and wait stage on system clocks, later stages on conversion clock ticks
        if (start & s_d.ctrl[CTRL_ON]) begin
            s_d.powered = 1'b1;
            // RC clock start waits one instruction period first
            s_d.tmr     = rc_mode ? CNT_W'(INSTR_CYC) : '0;
            s_d.st      = SACC_WAIT;
        end else if (s_q.st == SACC_WAIT) begin
            if (s_q.tmr != '0) begin
                s_d.tmr = s_q.tmr - 1'b1;
            end else if (s_q.pre_cnt != '0) begin
                s_d.tmr = s_q.pre_cnt;
                s_d.st  = SACC_PRE;
            end else begin
                s_d.tmr = s_q.acq_cnt;
                s_d.st  = SACC_ACQ;
            end
        end else if (tick & s_q.ctrl[CTRL_ON]) begin
            unique case (s_q.st)
                SACC_PRE: begin
                    s_d.tmr = s_q.tmr - 1'b1;
                    // Last precharge tick hands over to acquisition
                    if (s_q.tmr == CNT_W'(1)) begin
                        s_d.tmr = s_q.acq_cnt;
                        s_d.st  = SACC_ACQ;
                    end
                end
                SACC_ACQ: begin
                    if (s_q.tmr != '0) begin
                        s_d.tmr = s_q.tmr - 1'b1;
                    end else begin
                        s_d.bitn = SAR_LAST_BIT;
                        s_d.sar  = RES_W'(12'h800);
                        s_d.st   = SACC_CONV;
                    end
                end
                SACC_CONV: begin
                    // Keep or drop trial bit, try next lower
                    if (!i_compare_hi) begin
                        s_d.sar[s_q.bitn] = 1'b0;
                    end
                    if (s_q.bitn == 4'h0) begin
                        s_d.st = SACC_DONE;
                    end else begin
                        s_d.bitn = s_q.bitn - 1'b1;
                        s_d.sar[s_q.bitn - 1'b1] = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        // Clearing the enable aborts any conversion in progress; placed
        // after the sequencer so no stage can re-enter a busy state
        if (!s_d.ctrl[CTRL_ON]) begin
            s_d.st = SACC_IDLE;
        end
        // Completion: result, flags, sum, deviation
        if (s_q.st == SACC_DONE) begin
            s_d.st = SACC_IDLE;
            // With PSIS set, the old result moves to previous as the new one lands
            if (s_q.ctrl[CTRL_PSIS]) begin
                s_d.prev = s_q.result;
            end
            s_d.result = s_q.sar;
            if (!s_q.ctrl[CTRL_REPEAT_RUN]) begin
                s_d.ctrl[CTRL_GO] = 1'b0;
            end
            s_d.done_f = 1'b1;
            s_d.math_f = 1'b1;
            s_d.sum    = s_q.sum + 32'(s_q.sar);
            if (!s_q.ctrl[CTRL_DSEN] | s_q.odd) begin
                s_d.dev = diff;
                if (s_q.ctrl[CTRL_ABOV] ?
                    ($signed(diff) > $signed(s_q.thresh)) :
                    ($signed(diff) < $signed(s_q.thresh))) begin
                    s_d.thr_f = 1'b1;
                end
            end
            // Paired mode updates deviation and threshold on every second completion only
            s_d.odd = s_q.ctrl[CTRL_DSEN] & ~s_q.odd;
            if (i_sleep & ~s_q.ctrl[CTRL_IE]) begin
                s_d.powered = 1'b0;
            end
        end
        // Read data registered in setup phase
        if (rd) begin
            unique case (PADDR)
                ADDR_CTRL:   s_d.rdata = 32'(s_q.ctrl);
                ADDR_CLKSEL: s_d.rdata = 32'(s_q.div);
                ADDR_CHAN:   s_d.rdata = 32'(s_q.chan);
                ADDR_TIMING: s_d.rdata = {3'h0, s_q.acq_cnt,
                                          3'h0, s_q.pre_cnt};
                ADDR_RESULT: s_d.rdata = 32'(just);
                ADDR_PREV:   s_d.rdata = 32'(s_q.prev);
                ADDR_STATUS: s_d.rdata = 32'({s_q.pend,
                                  s_q.st != SACC_IDLE, s_q.math_f,
                                  s_q.thr_f, s_q.done_f});
                ADDR_THRESH: s_d.rdata = {s_q.thresh, s_q.setpoint};
                ADDR_SUM:    s_d.rdata = s_q.sum;
                ADDR_DEV:    s_d.rdata = 32'(s_q.dev);
                default:     s_d.rdata = 32'h0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register, cleared by reset
    // ------------------------------------------------------------------
    always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
        if (!I_RST_N) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign PRDATA  = s_q.rdata;
    assign PREADY  = 1'b1;
    assign PSLVERR = 1'b0;
    // Analog side request, driven as one whole struct
    assign o_analog = '{
        power:     s_q.powered & s_q.ctrl[CTRL_ON],
        sample:    s_q.st == SACC_ACQ,
        precharge: s_q.st == SACC_PRE,
        channel:   s_q.chan,
        pos_ref:   s_q.ctrl[CTRL_REF+1:CTRL_REF],
        trial:     s_q.sar
    };
    // Enabled pending event raises wake
    assign o_wake = (s_q.done_f & s_q.ctrl[CTRL_IE])
                  | (s_q.thr_f & s_q.ctrl[CTRL_TIE]);
endmodule

// *** verif/sacc_ana_model.sv ***
// Analog partner: per-channel source level and SAR comparator
`timescale 1ns/1ns
module sacc_ana_model (
    input  wire logic                i_clk,
    input  wire sacc_pkg::sacc_ana_s i_analog,
    output logic                     o_compare_hi
);
    import sacc_pkg::*;
    logic [RES_W-1:0] level;
    logic             junk_q = 1'b0;
    // ------------------------------------------------------------
    // Source level depends only on the selected channel
    // ------------------------------------------------------------
    assign level = {i_analog.channel, ~i_analog.channel};
    // Powered down: comparator output wanders every cycle
    always_ff @(posedge i_clk) begin
        junk_q <= ~junk_q;
    end
    // Keep the bit when the input is at or above the trial value
    assign o_compare_hi = i_analog.power ?
        (level >= i_analog.trial) : junk_q;
endmodule

// *** verif/sacc_chk_sva.sv ***
// Checker: port-level properties of the converter control block
`timescale 1ns/1ns
module sacc_chk
    import sacc_pkg::*;
(
    input wire logic        I_CLK_SYS,
    input wire logic        I_RST_N,
    input wire logic        PSEL,
    input wire logic        PENABLE,
    input wire logic        PWRITE,
    input wire logic [7:0]  PADDR,
    input wire logic [31:0] PRDATA,
    input wire sacc_ana_s   o_analog,
    input wire logic        o_wake
);
    logic wr_ctrl, wr_chan, wr_stat, rd_res;
    // Completed bus accesses per register
    assign wr_ctrl = PSEL && PENABLE && PWRITE && PADDR == ADDR_CTRL;
    assign wr_chan = PSEL && PENABLE && PWRITE && PADDR == ADDR_CHAN;
    assign wr_stat = PSEL && PENABLE && PWRITE && PADDR == ADDR_STATUS;
    assign rd_res  = PSEL && PENABLE && !PWRITE && PADDR == ADDR_RESULT;
    default clocking cb @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_RST_N);
    sequence s_released;
        $rose(I_RST_N);
    endsequence
    AST_RST_IDLE: assert property (s_released |->
        !o_analog.power && !o_analog.sample && !o_wake)
        else $error("not idle after reset");
    AST_CHAN_HOLD: assert property ($changed(o_analog.channel)
        |-> $past(wr_chan)) else $error("channel moved without write");
    AST_REF_HOLD: assert property ($changed(o_analog.pos_ref)
        |-> $past(wr_ctrl)) else $error("reference moved without write");
    AST_PRE_EXCL: assert property (o_analog.precharge
        |-> !o_analog.sample) else $error("precharge and sample overlap");
    AST_SAMPLE_PWR: assert property (o_analog.sample
        |-> o_analog.power) else $error("sampling while powered down");
    AST_WAKE_RISE: assert property ($rose(o_wake)
        |-> !$past(wr_stat)) else $error("wake raised by flag clear");
    AST_WAKE_FALL: assert property ($fell(o_wake)
        |-> $past(wr_stat || wr_ctrl)) else $error("flag cleared by hw");
    AST_RES_WIDTH: assert property (rd_res
        |-> PRDATA[31:16] == 16'h0) else $error("result wider than 16");
endmodule
bind sacc_top sacc_chk i_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PRDATA(PRDATA), .o_analog(o_analog), .o_wake(o_wake));

// *** verif/tb_sar_adc_conversion_control.sv ***
// Testbench: register-driven conversions against the analog model
`timescale 1ns/1ns
module tb_sar_adc_conversion_control;
    import sacc_pkg::*;
    localparam logic [31:0] CTL_R = 32'h11; // On, right justified
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr;
    logic sleep, rc_tick, trig, cmp_hi, wake;
    logic [7:0] paddr;
    logic [1:0] rc_cnt;
    logic [31:0] pwdata, prdata;
    sacc_ana_s ana;
    int failures, check_count;
    sacc_top i_dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .i_sleep(sleep), .i_rc_tick(rc_tick), .i_trigger(trig),
        .i_compare_hi(cmp_hi), .o_analog(ana), .o_wake(wake));
    sacc_ana_model i_ana (.i_clk(clk), .i_analog(ana),
        .o_compare_hi(cmp_hi));
    // ------------------------------------------------------------
    // Clock, RC tick enable, watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rc_cnt  <= 2'h0;
            rc_tick <= 1'b0;
        end else begin
            rc_cnt  <= rc_cnt + 2'h1;
            rc_tick <= (rc_cnt == 2'h0);
        end
    end
    initial begin
        repeat (60000) @(posedge clk);
        failures++;
        finish_test();
    end
    // ------------------------------------------------------------
    // Bus and compare helpers
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        // Access phase lasts until the slave answers ready
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic rchk(input string what, input logic [7:0] a,
                        input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(what, exp, q);
    endtask
    task automatic wait_done;
        logic [31:0] q;
        logic ok;
        ok = 1'b0;
        for (int n = 0; n < 1200 && !ok; n++) begin
            apb(1'b0, ADDR_STATUS, 32'h0, q);
            ok = (q[STAT_DONE] === 1'b1);
        end
        chk("done flag", 32'h1, {31'h0, ok});
    endtask
    function automatic logic [11:0] lvl(input logic [5:0] c);
        return {c, ~c};
    endfunction
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk("power", 32'h0, {31'h0, ana.power});
        rchk("ctrl", ADDR_CTRL, 32'h0);
        rchk("status", ADDR_STATUS, 32'h0);
        rchk("result", ADDR_RESULT, 32'h0);
        rchk("unmapped", 8'h30, 32'h0);
        $display("t_reset done");
    endtask
    task automatic t_convert(input logic [5:0] ch, input logic [5:0] code);
        logic [11:0] t;
        int k, n, i;
        logic [31:0] q;
        wr(ADDR_CLKSEL, {26'h0, code});
        wr(ADDR_CHAN, {26'h0, ch});
        wr(ADDR_CTRL, CTL_R);
        chk("channel", {26'h0, ch}, {26'h0, ana.channel});
        repeat (8) @(posedge clk);
        wr(ADDR_CTRL, CTL_R | 32'h2);
        t = ana.trial;
        k = 0;
        n = 0;
        for (i = 0; i < 4000 && k < 3; i++) begin
            @(negedge clk);
            if (ana.trial !== t) begin
                k++;
                n = (k == 3) ? i - n : i;
                t = ana.trial;
            end
        end
        chk("bit period", 32'(2 * (code + 1)), 32'(n));
        wait_done();
        rchk("result", ADDR_RESULT, {20'h0, lvl(ch)});
        rchk("go cleared", ADDR_CTRL, CTL_R);
        apb(1'b0, ADDR_STATUS, 32'h0, q);
        chk("flags", 32'h5, q & 32'h7);
        wr(ADDR_STATUS, 32'h7);
        rchk("flags cleared", ADDR_STATUS, 32'h0);
        $display("t_convert done");
    endtask
    task automatic t_left;
        wr(ADDR_CTRL, 32'h1);
        rchk("left", ADDR_RESULT, {16'h0, lvl(6'h2a), 4'h0});
        wr(ADDR_RESULT, 32'h123);
        rchk("left write", ADDR_RESULT, 32'h1230);
        wr(ADDR_CTRL, CTL_R);
        rchk("right write", ADDR_RESULT, 32'h123);
        $display("t_left done");
    endtask
    task automatic t_prev;
        wr(ADDR_CLKSEL, 32'h0);
        wr(ADDR_CHAN, 32'h7);
        repeat (8) @(posedge clk);
        wr(ADDR_CTRL, CTL_R | 32'h20);
        wr(ADDR_CTRL, CTL_R | 32'h22);
        wait_done();
        rchk("prev", ADDR_PREV, 32'h123);
        rchk("result", ADDR_RESULT, {20'h0, lvl(6'h7)});
        $display("t_prev done");
    endtask
    task automatic t_wake;
        wr(ADDR_CTRL, CTL_R | 32'h3080);
        chk("wake set", 32'h1, {31'h0, wake});
        chk("reference", 32'h3, {30'h0, ana.pos_ref});
        wr(ADDR_STATUS, 32'h7);
        chk("wake clear", 32'h0, {31'h0, wake});
        $display("t_wake done");
    endtask
    task automatic t_trigger;
        wr(ADDR_CTRL, CTL_R | 32'h100);
        trig <= 1'b1;
        wait_done();
        trig <= 1'b0;
        rchk("trig go", ADDR_CTRL, CTL_R | 32'h100);
        wr(ADDR_STATUS, 32'h7);
        // Trigger in Sleep off the RC clock waits for wake
        sleep <= 1'b1;
        trig <= 1'b1;
        repeat (40) @(posedge clk);
        rchk("held trig", ADDR_STATUS, 32'h10);
        sleep <= 1'b0;
        wait_done();
        trig <= 1'b0;
        wr(ADDR_STATUS, 32'h7);
        $display("t_trigger done");
    endtask
    task automatic t_sleep;
        wr(ADDR_CTRL, CTL_R | 32'h8);
        sleep <= 1'b1;
        wr(ADDR_CTRL, CTL_R | 32'ha);
        wait_done();
        @(negedge clk);
        chk("sleep power", 32'h0, {31'h0, ana.power});
        rchk("on kept", ADDR_CTRL, CTL_R | 32'h8);
        sleep <= 1'b0;
        wr(ADDR_STATUS, 32'h7);
        $display("t_sleep done");
    endtask
    task automatic t_abort;
        wr(ADDR_CTRL, CTL_R);
        wr(ADDR_CTRL, CTL_R | 32'h2);
        repeat (3) @(posedge clk);
        rst_n <= 1'b0;
        @(negedge clk);
        chk("abort power", 32'h0, {31'h0, ana.power});
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rchk("abort ctrl", ADDR_CTRL, 32'h0);
        $display("t_abort done");
    endtask
    task automatic t_thresh;
        wr(ADDR_CHAN, 32'h7);
        repeat (8) @(posedge clk);
        wr(ADDR_THRESH, 32'h0080_00f8);
        wr(ADDR_CTRL, 32'h651);
        wr(ADDR_CTRL, 32'h653);
        wait_done();
        rchk("first status", ADDR_STATUS, 32'h5);
        rchk("first dev", ADDR_DEV, 32'h0);
        wr(ADDR_STATUS, 32'h7);
        wr(ADDR_CTRL, 32'h653);
        wait_done();
        rchk("pair status", ADDR_STATUS, 32'h7);
        rchk("pair dev", ADDR_DEV, 32'h100);
        rchk("sum", ADDR_SUM, 32'h3f0);
        chk("thr wake", 32'h1, {31'h0, wake});
        $display("t_thresh done");
    endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, sleep, trig} = '0;
        {paddr, pwdata} = '0;
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        wr(ADDR_TIMING, 32'h0004_0002);
        t_convert(6'h15, 6'h00);
        t_convert(6'h2a, 6'h3f);
        t_left();
        t_prev();
        t_wake();
        t_trigger();
        t_sleep();
        t_abort();
        t_thresh();
        finish_test();
    end
endmodule
